// File: bench/adcsq_properties.sv
// Link checker for the converter sequencer serial link.
// Assumes both ends run on clk; placed beside the interface.
`timescale 1ns/1ps
`default_nettype none
module adcsq_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout_o,
  input wire logic dout_oe,
  input wire logic dout
);
  logic sclk_reg;
  logic [15:0] rise_reg;
  // Rising serial clocks seen in the current frame
  always_ff @(posedge clk) begin
    sclk_reg <= sclk;
    if (rst || cs_n) begin
      rise_reg <= 16'h0;
    end else if (sclk && !sclk_reg) begin
      rise_reg <= rise_reg + 16'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_oe_off; cs_n [*8] |-> !dout_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("data out driven while idle");
  property p_oe_on; !cs_n [*8] |-> dout_oe && dout == dout_o; endproperty
  a_oe_on: assert property (p_oe_on) else $error("data out not driven in frame");
  property p_idle_clk; cs_n && $past(cs_n) |-> !sclk; endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("serial clock moved while idle");
  property p_groups; $rose(cs_n) |-> rise_reg != 16'h0 && rise_reg[3:0] == 4'h0; endproperty
  a_groups: assert property (p_groups) else $error("frame not whole groups of 16");
  property p_din_low; $changed(din) |-> !sclk; endproperty
  a_din_low: assert property (p_din_low) else $error("data in changed with clock high");
  // Sampled one cycle after the rise, since data only moves on falls
  property p_zeros; $rose(sclk) && !cs_n && rise_reg[3:0] < 4'h4 |=> !dout_o; endproperty
  a_zeros: assert property (p_zeros) else $error("leading bit not zero");
  property p_end_low; $rose(cs_n) |-> !$past(sclk); endproperty
  a_end_low: assert property (p_end_low) else $error("frame ended with clock high");
  property p_enable; $fell(cs_n) |-> ##[1:8] dout_oe && !dout_o; endproperty
  a_enable: assert property (p_enable) else $error("no zero driven after select");
  c_single: cover property ($rose(cs_n) && rise_reg == 16'h10);
  c_triple: cover property ($rose(cs_n) && rise_reg == 16'h30);
  c_select: cover property ($fell(cs_n));
endmodule : adcsq_properties
`default_nettype wire

// File: bench/tb_top.sv
// Bench: Wishbone-driven host controller facing the sequencer over the link.
// Assumes one 20 MHz clock; results modelled from the sampler input.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import adcsq_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] wb_adr = 4'h0;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_rdat;
  logic wb_we = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic [3:0] wb_sel = 4'h0;
  logic wb_ack;
  logic [11:0] sample = 12'h0;
  logic [2:0] channel_sel;
  logic power_down;
  logic sample_switch;
  logic balance_switch;
  logic converting;
  logic [31:0] rd;
  int num_errors = 0;
  int comparisons = 0;
  int seed = 60;
  int cur_ch = 0;
  int exp_q[$];
  int k;
  int trk_run = 0;
  int cnv_run = 0;
  // Phase lengths in system clocks: serial periods times two half periods
  localparam int TRACK_CYC = ADCSQ_TRACK_CLKS * 2 * ADCSQ_SCLK_HALF_CYC;
  localparam int CONV_CYC = ADCSQ_CONV_CLKS * 2 * ADCSQ_SCLK_HALF_CYC;
  always #25 clk = ~clk;
  adcsq_if link_if();
  adcsq_host i_adcsq_host (.clk(clk), .rst(rst), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_we_i(wb_we), .wb_sel_i(wb_sel), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_ack_o(wb_ack), .link(link_if.host));
  adcsq_device i_adcsq_device (.clk(clk), .rst(rst), .link(link_if.dev), .sample_value(sample),
    .channel_sel(channel_sel), .sample_switch(sample_switch),
    .comparator_balance_switch(balance_switch), .power_down(power_down),
    .converting(converting));
  adcsq_properties i_adcsq_properties (.clk(clk), .rst(rst), .cs_n(link_if.cs_n),
    .sclk(link_if.sclk), .din(link_if.din), .dout_o(link_if.dout_o),
    .dout_oe(link_if.dout_oe), .dout(link_if.dout));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  // Each track run that ends in a hold must span three serial periods and each hold run thirteen
  always @(posedge clk) begin
    trk_run <= (sample_switch === 1'b1) ? trk_run + 1 : 0;
    cnv_run <= (converting === 1'b1) ? cnv_run + 1 : 0;
    if (!rst) begin
      check("balance switch", 32'(balance_switch), 32'(sample_switch));
      if (converting === 1'b1 && trk_run != 0) begin
        check("track cycles", 32'(trk_run), 32'(TRACK_CYC));
      end
      if (converting === 1'b0 && cnv_run != 0) begin
        check("convert cycles", 32'(cnv_run), 32'(CONV_CYC));
      end
    end
  end
  // Classic single cycle; held until ack is sampled high
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk);
    wb_adr <= a;
    wb_we <= w;
    wb_wdat <= d;
    wb_sel <= 4'hf;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (wb_ack === 1'b1) break;
    end
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n == 20) begin
      num_errors++;
      stop_test();
    end
  endtask : wb
  // One frame of n conversions sending channel ch, which the device uses from the second conversion on, with the sampler held at val
  task automatic frame(input logic [2:0] ch, input int n, input logic [11:0] val);
    int p;
    sample <= val;
    exp_q.push_back(int'(val));
    wb(ADCSQ_REG_CTRL, 1'b1, {13'h0, ch, n[7:0], 8'h1});
    check("channel before", 32'(channel_sel), cur_ch);
    for (p = 0; p < 400; p++) begin
      wb(ADCSQ_REG_STAT, 1'b0, 32'h0);
      if (rd[ADCSQ_STAT_BUSY] === 1'b0) break;
    end
    if (p == 400) begin
      num_errors++;
      stop_test();
    end
    check("status", rd & 32'h3, 32'h2);
    wb(ADCSQ_REG_DATA, 1'b0, 32'h0);
    check("result", rd & 32'hfff, exp_q.pop_front());
    cur_ch = int'(ch);
    check("channel after", 32'(channel_sel), cur_ch);
    check("power down", 32'(power_down), 32'h1);
  endtask : frame
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("channel reset", 32'(channel_sel), 32'h0);
    wb(4'hc, 1'b1, 32'hffffffff);
    wb(4'hc, 1'b0, 32'h0);
    check("unmapped", rd, 32'h0);
    frame(3'h5, 1, 12'hfff);
    $display("test first frame done");
    // Frames of one to three conversions; the longer ones exercise the retrack between groups
    for (k = 0; k < 8; k++) begin
      frame(k[2:0], 1 + k % 3, (k == 0) ? 12'h000 : 12'($random(seed)));
    end
    $display("test channel sweep done");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire

// File: hw/adcsq_device.sv
// Converter sequencer end: tracks, holds and shifts results on the serial link.
// Assumes link pins are asynchronous to clk; result comes from an abstract sampler port.
`timescale 1ns/1ps
`default_nettype none
module adcsq_device
  import adcsq_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  adcsq_if.dev link,
  input wire logic [ADCSQ_RES_BITS-1:0] sample_value,
  output logic [2:0] channel_sel,
  output logic sample_switch,
  output logic comparator_balance_switch,
  output logic power_down,
  output logic converting
);
  typedef struct packed {
    logic [1:0] cs_s;
    logic [1:0] sck_s;
    logic [1:0] din_s;
    logic cs_d;
    logic sck_d;
    logic active;
    logic [4:0] fall_cnt;
    logic [3:0] rise_cnt;
    logic [7:0] ctrl_sh;
    logic [2:0] chan;
    logic [2:0] next_chan;
    logic [11:0] res_sh;
    logic dout;
    logic pdn;
  } adcsq_dev_t;
  adcsq_dev_t s_reg, s_next;
  logic cs_n, sck, din, cs_fall, sck_fall, sck_rise, first_fall;
  logic [7:0] ctrl_full;
  always_comb begin
    s_next = s_reg;
    s_next.cs_s = {s_reg.cs_s[0], link.cs_n};
    s_next.sck_s = {s_reg.sck_s[0], link.sclk};
    s_next.din_s = {s_reg.din_s[0], link.din};
    cs_n = s_reg.cs_s[1];
    sck = s_reg.sck_s[1];
    din = s_reg.din_s[1];
    ctrl_full = {s_reg.ctrl_sh[6:0], din};
    s_next.cs_d = cs_n;
    s_next.sck_d = sck;
    cs_fall = s_reg.cs_d && !cs_n;
    sck_fall = s_reg.sck_d && !sck && !cs_n;
    sck_rise = !s_reg.sck_d && sck && !cs_n;
    first_fall = 1'b0;
    if (cs_n) begin
      s_next.active = 1'b0;
      s_next.fall_cnt = 5'h0;
      s_next.dout = 1'b0;
      s_next.pdn = 1'b1;
    end else begin
      // Clock low or falling with select counts the select fall as edge one
      if (cs_fall && !sck) begin
        first_fall = 1'b1;
      end else if (sck_fall) begin
        first_fall = 1'b1;
      end
      if (cs_fall) begin
        s_next.rise_cnt = 4'h0;
        s_next.active = 1'b0;
        s_next.fall_cnt = 5'h0;
      end
      if (first_fall) begin
        // Falls 1..16 then wrap back to track: continuous mode
        if (!s_reg.active || s_reg.fall_cnt == 5'(ADCSQ_FRAME_CLKS)
            || cs_fall) begin
          s_next.active = 1'b1;
          s_next.fall_cnt = 5'h1;
          s_next.pdn = 1'b0;
          s_next.chan = s_reg.next_chan;
          s_next.rise_cnt = 4'h0;
          s_next.dout = 1'b0;
        end else begin
          s_next.fall_cnt = s_reg.fall_cnt + 5'h1;
          if (s_reg.fall_cnt + 5'h1 == 5'(ADCSQ_ZERO_EDGES)) begin
            // Hold instant: freeze the unsigned straight binary sample
            s_next.res_sh = sample_value;
            s_next.dout = 1'b0;
          end else if (s_reg.fall_cnt + 5'h1 > 5'(ADCSQ_ZERO_EDGES)) begin
            s_next.dout = s_reg.res_sh[ADCSQ_RES_BITS-1];
            s_next.res_sh = {s_reg.res_sh[ADCSQ_RES_BITS-2:0], 1'b0};
          end else begin
            s_next.dout = 1'b0;
          end
          if (s_reg.fall_cnt + 5'h1 == 5'(ADCSQ_FRAME_CLKS)) begin
            s_next.pdn = 1'b1;
          end
        end
      end
      if (sck_rise && s_reg.rise_cnt < 4'(ADCSQ_CTRL_BITS)) begin
        s_next.ctrl_sh = ctrl_full;
        s_next.rise_cnt = s_reg.rise_cnt + 4'h1;
        if (s_reg.rise_cnt == 4'(ADCSQ_CTRL_BITS - 1)) begin
          // Only the channel field is kept; other bits fall away
          s_next.next_chan = ctrl_full[ADCSQ_CH_MSB:ADCSQ_CH_LSB];
        end
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.cs_s <= 2'h3;
      s_reg.cs_d <= 1'b1;
      s_reg.pdn <= 1'b1;
      s_reg.chan <= ADCSQ_CH_RESET;
      s_reg.next_chan <= ADCSQ_CH_RESET;
    end else begin
      s_reg <= s_next;
    end
  end
  // Track spans falls 1..3; hold begins at fall 4
  assign sample_switch = s_reg.active && s_reg.fall_cnt < 5'(ADCSQ_ZERO_EDGES);
  assign comparator_balance_switch = sample_switch;
  assign converting = s_reg.active && !sample_switch;
  assign channel_sel = s_reg.chan;
  assign power_down = s_reg.pdn;
  assign link.dout_o = s_reg.dout;
  // Synchronised select gates the driver, so enable lags the pin by two clocks
  assign link.dout_oe = !s_reg.cs_s[1];
endmodule : adcsq_device
`default_nettype wire

// File: hw/adcsq_host.sv
// Host controller end: Wishbone slave registers drive framed conversions.
// Assumes the device samples the link with its own clock.
//
// Decided for this implementation: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module adcsq_host
  import adcsq_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  adcsq_if.host link
);
  typedef enum {ST_IDLE, ST_LOW, ST_HIGH, ST_END} adcsq_st_t;
  typedef struct packed {
    adcsq_st_t st;
    logic ack;
    logic [31:0] rdat;
    logic [7:0] nconv;
    logic [2:0] chan;
    logic [7:0] conv_left;
    logic [3:0] bit_cnt;
    logic [7:0] div;
    logic cs_n;
    logic sclk;
    logic din;
    logic [15:0] rx_sh;
    logic [1:0] dout_s;
    logic [11:0] result;
    logic valid;
  } adcsq_host_t;
  adcsq_host_t s_reg, s_next;
  logic [7:0] ctrl_word;
  logic wr, rd;
  always_comb begin
    s_next = s_reg;
    s_next.ack = 1'b0;
    s_next.dout_s = {s_reg.dout_s[0], link.dout};
    wr = wb_cyc_i && wb_stb_i && wb_we_i && !s_reg.ack;
    rd = wb_cyc_i && wb_stb_i && !wb_we_i && !s_reg.ack;
    ctrl_word = 8'h0;
    ctrl_word[ADCSQ_CH_MSB:ADCSQ_CH_LSB] = s_reg.chan;
    if (wb_cyc_i && wb_stb_i && !s_reg.ack) begin
      s_next.ack = 1'b1;
    end
    if (rd) begin
      case (wb_adr_i)
        ADCSQ_REG_STAT: s_next.rdat = {30'h0, s_reg.valid, s_reg.st != ST_IDLE};
        ADCSQ_REG_DATA: begin
          s_next.rdat = {20'h0, s_reg.result};
          s_next.valid = 1'b0;
        end
        ADCSQ_REG_CTRL: s_next.rdat = {13'h0, s_reg.chan, s_reg.nconv, 8'h0};
        default: s_next.rdat = 32'h0;
      endcase
    end
    if (wr && wb_adr_i == ADCSQ_REG_CTRL && wb_sel_i[1] && wb_sel_i[2]) begin
      s_next.nconv = wb_dat_i[ADCSQ_CTRL_NCONV_LSB +: 8];
      s_next.chan = wb_dat_i[ADCSQ_CTRL_CH_LSB +: 3];
    end
    case (s_reg.st)
      ST_IDLE: begin
        if (wr && wb_adr_i == ADCSQ_REG_CTRL && wb_sel_i[0] && wb_dat_i[ADCSQ_CTRL_GO]) begin
          s_next.cs_n = 1'b0;
          s_next.conv_left = (wb_dat_i[ADCSQ_CTRL_NCONV_LSB +: 8] == 8'h0) ? 8'h1
                             : wb_dat_i[ADCSQ_CTRL_NCONV_LSB +: 8];
          s_next.bit_cnt = 4'h0;
          s_next.div = 8'h0;
          s_next.st = ST_LOW;
          s_next.din = 1'b0;
        end
      end
      ST_LOW: begin
        s_next.div = s_reg.div + 8'h1;
        if (s_reg.div == 8'(ADCSQ_SCLK_HALF_CYC - 1)) begin
          s_next.div = 8'h0;
          s_next.sclk = 1'b1;
          s_next.st = ST_HIGH;
        end
      end
      ST_HIGH: begin
        s_next.div = s_reg.div + 8'h1;
        if (s_reg.div == 8'(ADCSQ_SCLK_HALF_CYC - 1)) begin
          s_next.div = 8'h0;
          s_next.sclk = 1'b0;
          // Taken just before the fall: the device answers a few clocks after each
          // fall, too late for a sample at the next rise at this clock rate
          s_next.rx_sh = {s_reg.rx_sh[14:0], s_reg.dout_s[1]};
          s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
          // Fresh control word each conversion; change data on fall
          s_next.din = (s_reg.bit_cnt < 4'(ADCSQ_CTRL_BITS - 1)) ?
                       ctrl_word[3'(ADCSQ_CTRL_BITS - 2) - s_reg.bit_cnt[2:0]] : 1'b0;
          s_next.st = ST_LOW;
          if (s_reg.bit_cnt == 4'(ADCSQ_FRAME_CLKS - 1)) begin
            s_next.result = {s_reg.rx_sh[10:0], s_reg.dout_s[1]};
            s_next.valid = 1'b1;
            s_next.conv_left = s_reg.conv_left - 8'h1;
            s_next.din = ctrl_word[ADCSQ_CTRL_BITS-1];
            if (s_reg.conv_left == 8'h1) begin
              s_next.st = ST_END;
            end
          end
        end
      end
      ST_END: begin
        s_next.cs_n = 1'b1;
        s_next.din = 1'b0;
        s_next.st = ST_IDLE;
      end
      default: s_next.st = ST_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
      s_reg.cs_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end
  assign wb_ack_o = s_reg.ack;
  assign wb_dat_o = s_reg.rdat;
  assign link.cs_n = s_reg.cs_n;
  assign link.sclk = s_reg.sclk;
  assign link.din = s_reg.din;
endmodule : adcsq_host
`default_nettype wire

// File: hw/adcsq_if.sv
// Serial link between host controller and converter sequencer.
// Data out is released by the device outside a frame; the interface resolves the wire.
`timescale 1ns/1ps
`default_nettype none
interface adcsq_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout_o;
  logic dout_oe;
  logic dout;
  // Released line shows the inverse of dout_o, which the device clears to zero outside a frame, so a read outside the frame shows up
  assign dout = dout_oe ? dout_o : ~dout_o;
  modport dev (input cs_n, input sclk, input din, output dout_o, output dout_oe);
  modport host (output cs_n, output sclk, output din, input dout);
endinterface : adcsq_if
`default_nettype wire

// File: hw/adcsq_pkg.sv
// Shared constants for the eight-channel converter serial sequencer.
// Assumes a single 20 MHz system clock on both ends.
package adcsq_pkg;
  localparam int ADCSQ_CLK_NS = 50;
  localparam int ADCSQ_FRAME_CLKS = 16;
  localparam int ADCSQ_TRACK_CLKS = 3;
  localparam int ADCSQ_CONV_CLKS = 13;
  localparam int ADCSQ_ZERO_EDGES = 4;
  localparam int ADCSQ_CTRL_BITS = 8;
  localparam int ADCSQ_RES_BITS = 12;
  localparam int ADCSQ_CODE_STEPS = 4096;
  localparam int ADCSQ_CH_MSB = 5;
  localparam int ADCSQ_CH_LSB = 3;
  localparam logic [2:0] ADCSQ_CH_RESET = 3'h0;
  // Host serial clock half period, printed in ns, as system cycles (rounded down, min 1)
  localparam int ADCSQ_SCLK_HALF_NS = 200;
  localparam int ADCSQ_SCLK_HALF_CYC =
    (ADCSQ_SCLK_HALF_NS / ADCSQ_CLK_NS) < 1 ? 1 : ADCSQ_SCLK_HALF_NS / ADCSQ_CLK_NS;
  // Host command register offsets (Wishbone byte addresses)
  localparam logic [3:0] ADCSQ_REG_CTRL = 4'h0;
  localparam logic [3:0] ADCSQ_REG_STAT = 4'h4;
  localparam logic [3:0] ADCSQ_REG_DATA = 4'h8;
  localparam int ADCSQ_CTRL_GO = 0;
  localparam int ADCSQ_CTRL_NCONV_LSB = 8;
  localparam int ADCSQ_CTRL_CH_LSB = 16;
  localparam int ADCSQ_STAT_BUSY = 0;
  localparam int ADCSQ_STAT_VALID = 1;
endpackage : adcsq_pkg
